// ===== design/mio_params.svh
/*
 * constants for the port 6/7/8 pin logic: register offsets, reset values,
 * field positions and bus answers.
 * assumes inclusion by bare name from the design file and the bench.
 */
`ifndef MIO_PARAMS_SVH
`define MIO_PARAMS_SVH

`define MIO_OFS_P8_DIR     16'hFFBD
`define MIO_OFS_P7_PINS    16'hFFBE
`define MIO_OFS_P8_DATA    16'hFFBF
`define MIO_OFS_P6_DIR     16'hFFB9
`define MIO_OFS_TIMER_CTRL 16'hFFC0
`define MIO_OFS_MODE       16'hFFC4
`define MIO_OFS_SEL_BITS   16
`define MIO_P8_RESET       8'h80
`define MIO_P8_RSVD_BIT    7
`define MIO_P8_FIXED_MASK  7'h27
`define MIO_ALL_ONES_8     8'hFF
`define MIO_ZERO_32        32'h0000_0000
`define MIO_RESP_OKAY      2'h0
`define MIO_RESP_SLVERR    2'h2
`define MIO_CKS_EXT        3'h7
`define MIO_ZERO_8         8'h00
`define MIO_ZERO_7         7'h00
`define MIO_ZERO_6         6'h00
`define MIO_ZERO_3         3'h0

`endif

// ===== design/mio_pkg.sv
/*
 * types shared by the port 6/7/8 pin logic.
 * assumes mio_params.svh on the include path.
 */
package mio_pkg;
    // peripheral side of the port 8 pins
    typedef struct packed {
        logic [6:0] oe;
        logic [6:0] dout;
    } mio_periph_s;

    // timer control settings held for the port 6 pins
    typedef struct packed {
        logic       cmp_a_oe;
        logic [2:0] cks_t0;
        logic [2:0] cks_t1;
    } mio_timer_s;
endpackage : mio_pkg

// ===== design/mio_ports.sv
/*
 * port 6 (bits 5..0), port 7 and port 8 pin logic with an AXI4-Lite slave.
 * assumes pins come from outside the clock domain (two-flop sync), and that
 * peripherals give per-pin enable and data for port 8 pins they own.
 */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "mio_params.svh"

// Function
// [R1] port 6 timer input pins follow direction
// [R2] compare-A enable forces bit 1 output
// [R3] external clock pin feeds timer if selected
// [R4] port 7 eight-bit input only, no direction
// [R5] port 7 read returns present pin levels
// [R6] port 8 seven-bit bidirectional shared port
// [R7] port 8 bits 6,4,3 mode dependent
// [R8] port 8 direction one output, zero input
// [R9] port 8 direction write-only, reads all ones
// [R10] reset loads port 8 direction 0x80
// [R11] software standby keeps direction and drive
// [R12] standby returns peripheral pins to port control
// [R13] port 8 data bits 6..0, bit7 reads 1
// [R14] read gives data if output, pin if input
// [R15] reset sets data 0x80, standby keeps it; the code reloads it in hardware standby, software standby keeps it
// [R16] expanded modes multiplex host ram pins
// [R17] reserved top bit writes ignored, no effect
module mio_ports
    import mio_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] p6_in,
    output logic [5:0] p6_out,
    output logic [5:0] p6_oe_n,
    input wire logic compare_a_out,
    output logic capture_a_in,
    output logic capture_b_in,
    output logic capture_c_in,
    output logic capture_d_in,
    output logic second_timer_capture_in,
    output logic timer0_ext_clock,
    output logic timer1_ext_clock,
    input wire logic [7:0] p7_in,
    output logic [7:0] analog_in,
    input wire logic [6:0] p8_in,
    output logic [6:0] p8_out,
    output logic [6:0] p8_oe_n,
    input wire mio_periph_s periph,
    output logic [6:0] p8_pin_levels,
    output logic expanded_mode
);

    logic [5:0] p6_s1_q;
    logic [5:0] p6_s2_q;
    logic [7:0] p7_s1_q;
    logic [7:0] p7_s2_q;
    logic [6:0] p8_s1_q;
    logic [6:0] p8_s2_q;
    logic [6:0] p8_dir_q;
    logic [6:0] p8_data_q;
    logic [5:0] p6_dir_q;
    logic [5:0] p6_data_q;
    mio_timer_s tmr_q;
    logic mode_exp_q;
    logic aw_held_q;
    logic w_held_q;
    logic [15:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic [6:0] p8_own;
    logic [6:0] p8_drive;
    logic [6:0] p8_dval;
    logic [5:0] p6_drive;
    logic [5:0] p6_dval;
    logic [7:0] rd_d;
    logic rd_hit;
    logic wr_go;
    logic wr_hit;

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            p6_s1_q <= `MIO_ZERO_6;
            p6_s2_q <= `MIO_ZERO_6;
            p7_s1_q <= `MIO_ZERO_8;
            p7_s2_q <= `MIO_ZERO_8;
            p8_s1_q <= `MIO_ZERO_7;
            p8_s2_q <= `MIO_ZERO_7;
        end else if (ce) begin
            p6_s1_q <= p6_in;
            p6_s2_q <= p6_s1_q;
            p7_s1_q <= p7_in;
            p7_s2_q <= p7_s1_q;
            p8_s1_q <= p8_in;
            p8_s2_q <= p8_s1_q;
        end
    end

    // write channel capture, address and data in either order
    assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_hit = aw_q == `MIO_OFS_P8_DIR || aw_q == `MIO_OFS_P8_DATA
        || aw_q == `MIO_OFS_P6_DIR || aw_q == `MIO_OFS_TIMER_CTRL
        || aw_q == `MIO_OFS_MODE;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_q <= 16'h0000;
            wd_q <= `MIO_ZERO_32;
            ws_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MIO_RESP_OKAY;
        end else if (ce) begin
            s_axi_awready <= !aw_held_q && !s_axi_awready;
            s_axi_wready <= !w_held_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_q <= s_axi_awaddr[`MIO_OFS_SEL_BITS-1:0];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `MIO_RESP_OKAY : `MIO_RESP_SLVERR;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // port 8 registers; hardware standby acts as reset, software keeps
    always_ff @(posedge clk) begin
        if (!rstn || hw_standby) begin
            p8_dir_q <= 7'(`MIO_P8_RESET); // R10
            p8_data_q <= 7'(`MIO_P8_RESET); // R15
        end else if (ce && wr_go && ws_q[0]) begin
            // only bits 6..0 stored, top bit dropped
            if (aw_q == `MIO_OFS_P8_DIR) begin
                p8_dir_q <= wd_q[6:0]; // R17
            end
            if (aw_q == `MIO_OFS_P8_DATA) begin
                p8_data_q <= wd_q[6:0]; // R13
            end
        end
    end

    // own registers: port 6 direction/data, timer settings, mode
    always_ff @(posedge clk) begin
        if (!rstn || hw_standby) begin
            p6_dir_q <= `MIO_ZERO_6;
            p6_data_q <= `MIO_ZERO_6;
            tmr_q <= '0;
            mode_exp_q <= 1'b0;
        end else if (ce && wr_go) begin
            if (aw_q == `MIO_OFS_P6_DIR && ws_q[0]) begin
                p6_dir_q <= wd_q[5:0];
            end
            if (aw_q == `MIO_OFS_P6_DIR && ws_q[1]) begin
                p6_data_q <= wd_q[13:8];
            end
            if (aw_q == `MIO_OFS_TIMER_CTRL && ws_q[0]) begin
                tmr_q <= wd_q[6:0];
            end
            if (aw_q == `MIO_OFS_MODE && ws_q[0]) begin
                mode_exp_q <= wd_q[0];
            end
        end
    end

    // read data mux
    always_comb begin
        rd_hit = 1'b1;
        rd_d = `MIO_ZERO_8;
        case (s_axi_araddr[`MIO_OFS_SEL_BITS-1:0])
            `MIO_OFS_P8_DIR: rd_d = `MIO_ALL_ONES_8; // R9
            `MIO_OFS_P7_PINS: rd_d = p7_s2_q; // R5
            // R14 R13
            `MIO_OFS_P8_DATA: rd_d = {1'b1,
                (p8_dir_q & p8_data_q) | (~p8_dir_q & p8_s2_q)};
            `MIO_OFS_P6_DIR: rd_d = {2'b00, p6_dir_q};
            `MIO_OFS_TIMER_CTRL: rd_d = {1'b0, tmr_q};
            `MIO_OFS_MODE: rd_d = {7'h00, mode_exp_q};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `MIO_ZERO_32;
            s_axi_rresp <= `MIO_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_d};
                s_axi_rresp <= rd_hit ? `MIO_RESP_OKAY : `MIO_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // port 8 peripheral ownership, gone in software standby
    always_comb begin
        p8_own = sw_standby ? `MIO_ZERO_7 : periph.oe; // R12 R6
        // bits 6,4,3 carry host ram signals only in expanded mode
        if (!mode_exp_q) begin
            p8_own = p8_own & `MIO_P8_FIXED_MASK; // R7 R16
        end
        p8_drive = p8_own | p8_dir_q; // R8 R11
        p8_dval = (p8_own & periph.dout) | (~p8_own & p8_data_q);
    end

    // port 6: bit 1 forced by compare-A enable
    always_comb begin
        p6_drive = p6_dir_q; // R1
        p6_dval = p6_data_q;
        if (tmr_q.cmp_a_oe) begin
            p6_drive[1] = 1'b1; // R2
            p6_dval[1] = compare_a_out;
        end
    end

    // registered pin and peripheral outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            p8_out <= `MIO_ZERO_7;
            p8_oe_n <= 7'h7F;
            p6_out <= `MIO_ZERO_6;
            p6_oe_n <= 6'h3F;
            analog_in <= `MIO_ZERO_8;
            p8_pin_levels <= `MIO_ZERO_7;
            expanded_mode <= 1'b0;
            capture_a_in <= 1'b0;
            capture_b_in <= 1'b0;
            capture_c_in <= 1'b0;
            capture_d_in <= 1'b0;
            second_timer_capture_in <= 1'b0;
            timer0_ext_clock <= 1'b0;
            timer1_ext_clock <= 1'b0;
        end else if (ce) begin
            p8_out <= p8_dval;
            p8_oe_n <= ~p8_drive;
            p6_out <= p6_dval;
            p6_oe_n <= ~p6_drive;
            analog_in <= p7_s2_q; // R4
            p8_pin_levels <= p8_s2_q;
            expanded_mode <= mode_exp_q;
            capture_a_in <= p6_s2_q[2] & ~p6_dir_q[2]; // R1
            second_timer_capture_in <= p6_s2_q[2] & ~p6_dir_q[2];
            capture_b_in <= p6_s2_q[3] & ~p6_dir_q[3];
            capture_c_in <= p6_s2_q[4] & ~p6_dir_q[4];
            capture_d_in <= p6_s2_q[5] & ~p6_dir_q[5];
            timer0_ext_clock <= p6_s2_q[0] & ~p6_dir_q[0]
                & (tmr_q.cks_t0 == `MIO_CKS_EXT); // R3
            timer1_ext_clock <= p6_s2_q[0] & ~p6_dir_q[0]
                & (tmr_q.cks_t1 == `MIO_CKS_EXT);
        end
    end

endmodule : mio_ports

// ===== verification/mio_pin_model.sv
/* far side of port 6 and port 8: outside drivers on the wires.
   assumes oe_n low means the block drives; lvl6/lvl8 set by the bench. */
`timescale 1ns/100ps
module mio_pin_model (
    input wire logic [5:0] p6_out,
    input wire logic [5:0] p6_oe_n,
    input wire logic [5:0] lvl6,
    input wire logic [6:0] p8_out,
    input wire logic [6:0] p8_oe_n,
    input wire logic [6:0] lvl8,
    output logic [5:0] p6_in,
    output logic [6:0] p8_in
);
    // block level where it drives, outside level elsewhere
    assign p6_in = (p6_out & ~p6_oe_n) | (lvl6 & p6_oe_n);
    assign p8_in = (p8_out & ~p8_oe_n) | (lvl8 & p8_oe_n);
endmodule : mio_pin_model

// ===== verification/mio_ports_sva.sv
/* pin and standby assertions for mio_ports.
   assumes ce high while checked; bound below by port names. */
`timescale 1ns/100ps
module mio_ports_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic s_axi_bvalid,
    input wire logic [5:0] p6_oe_n,
    input wire logic capture_a_in,
    input wire logic capture_b_in,
    input wire logic second_timer_capture_in,
    input wire logic timer0_ext_clock,
    input wire logic timer1_ext_clock,
    input wire logic [7:0] p7_in,
    input wire logic [7:0] analog_in,
    input wire logic [6:0] p8_in,
    input wire logic [6:0] p8_out,
    input wire logic [6:0] p8_oe_n,
    input wire logic [6:0] p8_pin_levels
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || !ce);
    chk_hw_release: assert property (
        hw_standby [*2] |=> p8_oe_n == 7'h7F) else $error("p8 driven");
    chk_cap_gate: assert property (
        !p6_oe_n[3] |-> !capture_b_in) else $error("capture b open");
    chk_cap_pair: assert property (
        capture_a_in == second_timer_capture_in
        && (!capture_a_in || p6_oe_n[2])) else $error("pair");
    chk_t0_clk: assert property (
        timer0_ext_clock |-> p6_oe_n[0]) else $error("t0 clk");
    chk_t1_clk: assert property (
        timer1_ext_clock |-> p6_oe_n[0]) else $error("t1 clk");
    chk_p7_follow: assert property (
        $stable(p7_in) [*5] |-> analog_in == p7_in) else $error("p7");
    chk_p8_levels: assert property (
        $stable(p8_in) [*5] |-> p8_pin_levels == p8_in) else $error("p8");
    chk_stby_hold: assert property (
        sw_standby && $past(sw_standby) && $past(sw_standby, 2)
        && !hw_standby && !$past(hw_standby, 2)
        && !s_axi_bvalid && !$past(s_axi_bvalid)
        |-> $stable(p8_oe_n) && $stable(p8_out)) else $error("stby");
endmodule : mio_ports_sva
bind mio_ports mio_ports_sva i_sva (.*);

// ===== verification/tb.sv
/* self-checking bench for mio_ports.
   assumes mio_pin_model on the pins and the checker bound to the block. */
`timescale 1ns/100ps
`include "mio_params.svh"
module tb
    import mio_pkg::*;
;
    logic clk = '0, rstn = '0, ce = '1, hw_standby = '0, sw_standby = '0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, compare_a_out = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, expanded_mode;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata, rv;
    logic [5:0] p6_in, p6_out, p6_oe_n, lvl6 = '0;
    logic [7:0] p7_in = '0, analog_in;
    logic [6:0] p8_in, p8_out, p8_oe_n, p8_pin_levels, lvl8 = '0;
    mio_periph_s periph = '0;
    logic capture_a_in, capture_b_in, capture_c_in, capture_d_in;
    logic second_timer_capture_in, timer0_ext_clock, timer1_ext_clock;
    int miscompares = 0, checks_done = 0, cycles = 0;
    mio_ports i_dut (.*);
    mio_pin_model i_pins (.*);
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic final_report;
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [31:0] a, d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask : settle
    task automatic t_reset;
        lvl8 <= 7'h55;
        settle();
        cmp("p8 oe_n", 32'h7F, p8_oe_n);
        rd(`MIO_OFS_P8_DIR);
        cmp("dir rd", 32'hFF, rv);
        rd(`MIO_OFS_P8_DATA);
        cmp("data rd", 32'hD5, rv);
    endtask : t_reset
    task automatic t_p8;
        wr(`MIO_OFS_P8_DIR, 32'hFF);
        wr(`MIO_OFS_P8_DATA, 32'h2A);
        settle();
        cmp("p8 out", 32'h2A, p8_out);
        cmp("p8 oe_n", 32'h00, p8_oe_n);
        rd(`MIO_OFS_P8_DATA);
        cmp("data rd", 32'hAA, rv);
        wr(`MIO_OFS_P8_DIR, 32'h0F);
        settle();
        cmp("p8 oe_n", 32'h70, p8_oe_n);
        rd(`MIO_OFS_P8_DATA);
        cmp("mixed rd", 32'hDA, rv);
    endtask : t_p8
    task automatic t_p7;
        logic [7:0] v[2] = '{8'hA5, 8'h3C};
        for (int i = 0; i < 2; i++) begin
            p7_in <= v[i];
            settle();
            cmp("analog", {24'h0, v[i]}, analog_in);
            rd(`MIO_OFS_P7_PINS);
            cmp("p7 rd", {24'h0, v[i]}, rv);
        end
        ce <= 1'h0;
        p7_in <= 8'h00;
        settle();
        cmp("frozen", 32'h3C, analog_in);
        ce <= 1'h1;
        settle();
    endtask : t_p7
    task automatic t_p6;
        wr(`MIO_OFS_P6_DIR, 32'h0808);
        lvl6 <= 6'h35;
        compare_a_out <= 1'h1;
        wr(`MIO_OFS_TIMER_CTRL, 32'h78);
        settle();
        cmp("p6 oe_n", 32'h35, p6_oe_n);
        cmp("p6 out", 32'h0A, p6_out);
        cmp("cap d", 32'h1, capture_d_in);
        cmp("cap c", 32'h1, capture_c_in);
        cmp("cap a", 32'h1, capture_a_in);
        cmp("cap b", 32'h0, capture_b_in);
        cmp("ext clk", 32'h2, {timer0_ext_clock, timer1_ext_clock});
        wr(`MIO_OFS_TIMER_CTRL, 32'h3F);
        settle();
        cmp("p6 oe_n", 32'h37, p6_oe_n);
        cmp("ext clk", 32'h3, {timer0_ext_clock, timer1_ext_clock});
    endtask : t_p6
    task automatic t_stby;
        periph <= '{oe: 7'h70, dout: 7'h40};
        settle();
        cmp("single oe_n", 32'h50, p8_oe_n);
        wr(`MIO_OFS_MODE, 32'h01);
        periph <= '{oe: 7'h50, dout: 7'h40};
        settle();
        cmp("expanded", 32'h1, expanded_mode);
        cmp("p8 oe_n", 32'h20, p8_oe_n);
        cmp("p8 out", 32'h4A, p8_out & 7'h5F);
        rd(`MIO_OFS_P8_DATA);
        cmp("periph rd", 32'hCA, rv);
        sw_standby <= 1'h1;
        settle();
        cmp("p8 oe_n", 32'h70, p8_oe_n);
        cmp("p8 out", 32'hA, p8_out[3:0]);
        sw_standby <= 1'h0;
        periph <= '0;
    endtask : t_stby
    task automatic t_hw;
        hw_standby <= 1'h1;
        repeat (3) @(posedge clk);
        hw_standby <= 1'h0;
        settle();
        cmp("p8 oe_n", 32'h7F, p8_oe_n);
        rd(`MIO_OFS_P8_DATA);
        cmp("data rd", 32'hD5, rv);
        rd(32'h1000);
        cmp("unmapped", {30'h0, `MIO_RESP_SLVERR}, rr);
    endtask : t_hw
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        t_reset();
        t_p8();
        t_p7();
        t_p6();
        t_stby();
        t_hw();
        final_report();
    end
endmodule : tb
